// ===== atpg_pkg.sv
// Package for the converter output test-pattern generator.
// Assumes one encode clock and byte registers written at their printed offsets.
package atpg_pkg;

  // Sample and code widths.
  localparam int SAMPLE_W = 14;
  localparam int CODE_W = 4;

  // Register offsets.
  localparam logic [11:0] ADDR_DDC0_EN = 12'h327;
  localparam logic [11:0] ADDR_DDC1_EN = 12'h347;
  localparam logic [11:0] ADDR_DDC2_EN = 12'h367;
  localparam logic [11:0] ADDR_DDC3_EN = 12'h387;
  localparam logic [11:0] ADDR_MODE = 12'h550;
  localparam logic [11:0] ADDR_USER_FIRST = 12'h551;
  localparam logic [11:0] ADDR_USER_LAST = 12'h558;

  // Field positions and reset values.
  localparam int CODE_LSB = 0;
  localparam int BIT_RST_LONG = 4;
  localparam int BIT_RST_SHORT = 5;
  localparam int BIT_SINGLE = 7;
  localparam int BIT_DDC_I = 0;
  localparam int BIT_DDC_Q = 2;
  localparam int CHAN_A = 0;
  localparam int CHAN_B = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Pattern words and seeds.
  localparam logic [13:0] WORD_ZERO = 14'h0000;
  localparam logic [13:0] WORD_POS = 14'h1FFF;
  localparam logic [13:0] WORD_NEG = 14'h2000;
  localparam logic [13:0] WORD_CHK0 = 14'h1555;
  localparam logic [13:0] WORD_CHK1 = 14'h2AAA;
  localparam logic [13:0] WORD_ONES = 14'h3FFF;
  localparam logic [13:0] RAMP_STEP = 14'h0001;
  localparam logic [22:0] SEED_LONG = 23'h003AFF;
  localparam logic [8:0] SEED_SHORT = 9'h092;
  localparam int LONG_TAP_HI = 22;
  localparam int LONG_TAP_LO = 17;
  localparam int SHORT_TAP_HI = 8;
  localparam int SHORT_TAP_LO = 4;
  localparam int PN_OUT_BIT = 0;

  // Test-mode codes.
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_MID = 4'b0001,
    MODE_POS = 4'b0010,
    MODE_NEG = 4'b0011,
    MODE_CHECKER = 4'b0100,
    MODE_PN_LONG = 4'b0101,
    MODE_PN_SHORT = 4'b0110,
    MODE_TOGGLE = 4'b0111,
    MODE_USER = 4'b1000,
    MODE_RAMP = 4'b1111
  } atpg_mode_e;

  // User-pattern walk.
  typedef enum logic [2:0] {
    USR_P0 = 3'b000,
    USR_P1 = 3'b001,
    USR_P2 = 3'b010,
    USR_P3 = 3'b011,
    USR_DONE = 3'b100
  } atpg_user_e;

  // Sample pair for channels A and B.
  typedef struct packed {
    logic [13:0] b;
    logic [13:0] a;
  } atpg_pair_s;

  // One down-converter output.
  typedef struct packed {
    logic [13:0] q;
    logic [13:0] i;
  } atpg_iq_s;

  // Generator state of one channel.
  typedef struct packed {
    logic [22:0] pn_long;
    logic [8:0] pn_short;
    logic phase;
    logic [13:0] ramp;
    atpg_user_e user;
    logic [3:0] code_last;
  } atpg_gen_s;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0][7:0] mode;
    logic [7:0][7:0] user_pat;
    logic [3:0][7:0] ddc_en;
    atpg_gen_s [1:0] gen;
    logic [1:0][13:0] word;
    logic [1:0] active;
    logic [1:0] bypass;
    logic [3:0][27:0] ddc;
    logic [7:0] rdata;
  } atpg_state_s;

endpackage : atpg_pkg

// ===== atpg_gen.sv
// Output test-pattern generator standing in for converter samples.
// Assumes clk_in is the encode clock and register strobes are synchronous to it.
`timescale 1ns/1ns

// What this block does
// RL1 - Four-bit code selects pattern; zero means off.
// RL2 - Active pattern replaces the converter samples.
// RL3 - Some patterns skip output formatting.
// RL4 - Two reset bits reseed the PN generators.
// RL5 - Generators step only on encode clock.
// RL6 - Software enables test per active down-converter.
// RL7 - I carries channel A, Q channel B.
// RL8 - Codes 1-3 give fixed 14-bit words.
// RL9 - Code 4 alternates checkerboard words, 0x1555 first.
// RL10 - Code 5 gives long PN sequence.
// RL11 - Code 6 gives short PN sequence.
// RL12 - Code 7 toggles zeros and ones, zeros first.
// RL13 - Code 8 repeats four user patterns.
// RL14 - Single mode plays patterns once, then zeros.
// RL15 - Code 15 ramps by one, wrapping.
// RL16 - Unassigned codes behave like code zero.
// RL17 - One 14-bit sample per clock.
module atpg_gen (
  // Clock and reset.
  input logic clk_in,
  input logic sys_rst_in,
  // Register access at printed offsets.
  input logic reg_wr_in,
  input logic [11:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic [1:0] reg_chan_sel_in,
  output logic [7:0] reg_rdata_out,
  // Converter samples and down-converter path.
  input atpg_pkg::atpg_pair_s adc_sample_in,
  input logic ddc_mode_in,
  input atpg_pkg::atpg_iq_s [3:0] ddc_in,
  // Samples toward output formatting.
  output atpg_pkg::atpg_pair_s sample_out,
  output logic [1:0] test_active_out,
  output logic [1:0] fmt_bypass_out,
  output atpg_pkg::atpg_iq_s [3:0] ddc_out
);
  import atpg_pkg::*;

  atpg_state_s s_reg;
  atpg_state_s s_next;
  atpg_gen_s g;
  logic [3:0] code;
  logic [13:0] word;
  logic [13:0] adc_word;
  logic [11:0] user_off;
  logic [7:0] rd_val;
  logic [13:0] ddc_i;
  logic [13:0] ddc_q;

  // Steps the long PN register one sample; returns {new bits, state}.
  // The register shifts toward its low end and the bit that leaves it is
  // the next output bit, first bit out in the word's MSB, so the low bits
  // of the seed come out bit-reversed as the first sample.
  function automatic logic [36:0] pn_long_step(input logic [22:0] st);
    logic [22:0] s;
    logic [13:0] w;
    logic fb;
    s = st;
    w = WORD_ZERO;
    for (int k = 0; k < SAMPLE_W; k++)
    begin
      // Feedback joins the leaving bit with the tap at the polynomial spacing.
      fb = s[PN_OUT_BIT] ^ s[LONG_TAP_HI - LONG_TAP_LO];
      w = {w[SAMPLE_W-2:0], s[PN_OUT_BIT]};
      s = {fb, s[LONG_TAP_HI:PN_OUT_BIT+1]};
    end
    return {w, s};
  endfunction : pn_long_step

  // Steps the short PN register one sample; returns {new bits, state}.
  // It is built like the long one: low bit out first, feedback in at the top.
  // Fourteen shifts per sample keep the word aligned with the register.
  function automatic logic [22:0] pn_short_step(input logic [8:0] st);
    logic [8:0] s;
    logic [13:0] w;
    logic fb;
    s = st;
    w = WORD_ZERO;
    for (int k = 0; k < SAMPLE_W; k++)
    begin
      // Feedback joins the leaving bit with the tap at the polynomial spacing.
      fb = s[PN_OUT_BIT] ^ s[SHORT_TAP_HI - SHORT_TAP_LO];
      w = {w[SAMPLE_W-2:0], s[PN_OUT_BIT]};
      s = {fb, s[SHORT_TAP_HI:PN_OUT_BIT+1]};
    end
    return {w, s};
  endfunction : pn_short_step

  // Picks user pattern k from its two bytes and keeps bits 15:2.
  function automatic logic [13:0] user_word(input logic [7:0][7:0] b,
                                            input logic [1:0] k);
    logic [15:0] w;
    w = {b[{k, 1'b1}], b[{k, 1'b0}]};
    return w[15:2];
  endfunction : user_word

  // Tells whether an offset falls among the user-pattern bytes.
  // Read and write decode share it so they can never disagree.
  function automatic logic user_hit(input logic [11:0] a);
    return (a >= ADDR_USER_FIRST) && (a <= ADDR_USER_LAST);
  endfunction : user_hit

  // Tells whether a code selects a pattern at all.
  function automatic logic code_active(input logic [3:0] c);
    case (c)
      MODE_MID, MODE_POS, MODE_NEG, MODE_CHECKER, MODE_PN_LONG,
      MODE_PN_SHORT, MODE_TOGGLE, MODE_USER, MODE_RAMP: return 1'b1;
      default: return 1'b0; // RL16
    endcase
  endfunction : code_active

  // Tells whether a pattern skips output formatting.
  function automatic logic code_bypass(input logic [3:0] c);
    case (c)
      MODE_PN_LONG, MODE_PN_SHORT, MODE_TOGGLE, MODE_USER, MODE_RAMP:
        return 1'b1; // RL3
      default: return 1'b0;
    endcase
  endfunction : code_bypass

  // Register read value, channel A wins when both channels are selected.
  // Unmapped offsets read as zero so software sees no stale byte.
  // The value is registered, so it appears one cycle after the address.
  always_comb
  begin
    rd_val = REG_RESET;
    user_off = reg_addr_in - ADDR_USER_FIRST;
    case (reg_addr_in)
      ADDR_DDC0_EN: rd_val = s_reg.ddc_en[0];
      ADDR_DDC1_EN: rd_val = s_reg.ddc_en[1];
      ADDR_DDC2_EN: rd_val = s_reg.ddc_en[2];
      ADDR_DDC3_EN: rd_val = s_reg.ddc_en[3];
      ADDR_MODE: rd_val = reg_chan_sel_in[CHAN_A] ? s_reg.mode[CHAN_A]
                                                  : s_reg.mode[CHAN_B];
      default:
      begin
        if (user_hit(reg_addr_in))
        begin
          rd_val = s_reg.user_pat[user_off[2:0]];
        end
      end
    endcase
  end

  // Next state: register writes, pattern generators and output selection.
  always_comb
  begin
    s_next = s_reg;
    g = s_reg.gen[CHAN_A];
    code = MODE_OFF;
    word = WORD_ZERO;
    adc_word = WORD_ZERO;
    ddc_i = WORD_ZERO;
    ddc_q = WORD_ZERO;
    s_next.rdata = rd_val;

    // Software writes; the mode register is kept per channel.
    // Both copies take the byte when both channel bits are set.
    // Writes to unmapped offsets fall through and change nothing.
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        ADDR_DDC0_EN: s_next.ddc_en[0] = reg_wdata_in; // RL6
        ADDR_DDC1_EN: s_next.ddc_en[1] = reg_wdata_in; // RL6
        ADDR_DDC2_EN: s_next.ddc_en[2] = reg_wdata_in; // RL6
        ADDR_DDC3_EN: s_next.ddc_en[3] = reg_wdata_in; // RL6
        ADDR_MODE:
        begin
          if (reg_chan_sel_in[CHAN_A])
          begin
            s_next.mode[CHAN_A] = reg_wdata_in; // RL1
          end
          if (reg_chan_sel_in[CHAN_B])
          begin
            s_next.mode[CHAN_B] = reg_wdata_in; // RL1
          end
        end
        default:
        begin
          if (user_hit(reg_addr_in))
          begin
            s_next.user_pat[user_off[2:0]] = reg_wdata_in; // RL13
          end
        end
      endcase
    end

    // One sample per clock for each channel.
    for (int c = 0; c < 2; c++)
    begin
      g = s_reg.gen[c];
      code = s_reg.mode[c][CODE_LSB +: CODE_W]; // RL1
      adc_word = (c == CHAN_A) ? adc_sample_in.a : adc_sample_in.b;
      // A new code restarts its sequence from the start.
      // Without this a pattern would resume wherever an earlier run of it
      // stopped, and capture logic could not predict the first sample.
      if (code != g.code_last)
      begin
        g.code_last = code;
        g.phase = 1'b0;
        g.ramp = WORD_ZERO;
        g.user = USR_P0;
        g.pn_long = SEED_LONG;
        g.pn_short = SEED_SHORT;
      end
      case (code)
        MODE_MID: word = WORD_ZERO; // RL8
        MODE_POS: word = WORD_POS; // RL8
        MODE_NEG: word = WORD_NEG; // RL8
        MODE_CHECKER:
        begin
          word = g.phase ? WORD_CHK1 : WORD_CHK0; // RL9
          g.phase = ~g.phase;
        end
        MODE_PN_LONG: {word, g.pn_long} = pn_long_step(g.pn_long); // RL10
        MODE_PN_SHORT: {word, g.pn_short} = pn_short_step(g.pn_short); // RL11
        MODE_TOGGLE:
        begin
          word = g.phase ? WORD_ONES : WORD_ZERO; // RL12
          g.phase = ~g.phase;
        end
        MODE_USER:
        begin
          case (g.user)
            USR_P0, USR_P1, USR_P2:
            begin
              word = user_word(s_reg.user_pat, g.user[1:0]); // RL13
              g.user = atpg_user_e'(g.user + 3'b001);
            end
            USR_P3:
            begin
              word = user_word(s_reg.user_pat, g.user[1:0]);
              // Single mode parks after the fourth pattern.
              g.user = s_reg.mode[c][BIT_SINGLE] ? USR_DONE : USR_P0; // RL14
            end
            USR_DONE: word = WORD_ZERO; // RL14
            default: g.user = USR_P0;
          endcase
        end
        MODE_RAMP:
        begin
          word = g.ramp; // RL15
          g.ramp = g.ramp + RAMP_STEP;
        end
        default: word = adc_word; // RL16
      endcase
      // Reset bits hold the PN registers at their seeds.
      // They act as levels: while one is set every sample repeats the
      // first word, and clearing it lets the sequence run from the seed.
      if (s_reg.mode[c][BIT_RST_LONG] || s_reg.mode[c][BIT_RST_SHORT])
      begin
        g.pn_long = SEED_LONG; // RL4
        g.pn_short = SEED_SHORT; // RL4
      end
      s_next.gen[c] = g;
      s_next.word[c] = word; // RL2 RL17
      s_next.active[c] = code_active(code); // RL2
      s_next.bypass[c] = code_active(code) && code_bypass(code); // RL3
    end

    // Down-converter outputs take channel A on I and channel B on Q.
    // A converter is overridden only when its own enable bit is set and the
    // channel really runs a pattern, so an idle channel never blanks it.
    for (int d = 0; d < 4; d++)
    begin
      ddc_i = ddc_in[d].i;
      ddc_q = ddc_in[d].q;
      if (ddc_mode_in && s_reg.ddc_en[d][BIT_DDC_I] && s_next.active[CHAN_A])
      begin
        ddc_i = s_next.word[CHAN_A]; // RL7
      end
      if (ddc_mode_in && s_reg.ddc_en[d][BIT_DDC_Q] && s_next.active[CHAN_B])
      begin
        ddc_q = s_next.word[CHAN_B]; // RL7
      end
      s_next.ddc[d] = {ddc_q, ddc_i};
    end
  end

  // State register; all test output is off after reset.
  // The PN registers leave reset at their seeds, never at all zeros,
  // because an all-zero register would lock the sequence at zero.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s_reg <= '0; // RL1
      s_reg.gen[CHAN_A].pn_long <= SEED_LONG;
      s_reg.gen[CHAN_B].pn_long <= SEED_LONG;
      s_reg.gen[CHAN_A].pn_short <= SEED_SHORT;
      s_reg.gen[CHAN_B].pn_short <= SEED_SHORT;
    end
    else
    begin
      s_reg <= s_next; // RL5
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata_out = s_reg.rdata;
  assign sample_out.a = s_reg.word[CHAN_A];
  assign sample_out.b = s_reg.word[CHAN_B];
  assign test_active_out = s_reg.active;
  assign fmt_bypass_out = s_reg.bypass;
  assign ddc_out = s_reg.ddc;

endmodule : atpg_gen

// ===== atpg_gen_chk.sv
// Port checker for the converter test-pattern generator, channel A.
// Assumes one encode clock and the mode register written at ADDR_MODE.
`timescale 1ns/1ns
module atpg_gen_chk (
  // Clock and reset.
  input logic clk_in,
  input logic sys_rst_in,
  // Register port.
  input logic reg_wr_in,
  input logic [11:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic [1:0] reg_chan_sel_in,
  input logic [7:0] reg_rdata_out,
  // Sample path.
  input atpg_pkg::atpg_pair_s adc_sample_in,
  input atpg_pkg::atpg_pair_s sample_out,
  input logic [1:0] test_active_out,
  input logic [1:0] fmt_bypass_out
);
  import atpg_pkg::*;
  logic [3:0] code_reg;
  logic [1:0] age_reg;
  wire mapped = reg_addr_in inside {ADDR_DDC0_EN, ADDR_DDC1_EN, ADDR_DDC2_EN, ADDR_DDC3_EN,
    [ADDR_MODE:ADDR_USER_LAST]};
  // Mirrors the channel A code and counts samples since it last changed.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      code_reg <= 4'h0;
      age_reg <= 2'h0;
    end
    else if (reg_wr_in && reg_addr_in == ADDR_MODE && reg_chan_sel_in[0] &&
      reg_wdata_in[3:0] != code_reg)
    begin
      code_reg <= reg_wdata_in[3:0];
      age_reg <= 2'h0;
    end
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_rd_unmapped:
    assert property (!mapped |=> reg_rdata_out == 8'h00) else $error("Unmapped read not zero.");
  a_pass_adc:
    assert property (!$past(sys_rst_in) && !test_active_out[0] |->
      sample_out.a == $past(adc_sample_in.a)) else $error("Idle sample not passed.");
  a_code_active:
    assert property (age_reg != 2'h0 |-> test_active_out[0] == (code_reg inside {[1:8], 15}))
      else $error("Active flag wrong.");
  a_bypass_code:
    assert property (age_reg != 2'h0 |-> fmt_bypass_out[0] == (code_reg inside {[5:8], 15}))
      else $error("Bypass flag wrong.");
  a_fixed_word:
    assert property (age_reg != 2'h0 && code_reg inside {[1:3]} |-> sample_out.a ==
      (code_reg == 4'h1 ? 14'h0000 : code_reg == 4'h2 ? 14'h1FFF : 14'h2000))
      else $error("Fixed word wrong.");
  a_checker_alt:
    assert property (age_reg != 2'h0 && code_reg == 4'h4 |-> sample_out.a ==
      (age_reg == 2'h1 ? 14'h1555 : $past(sample_out.a) ^ 14'h3FFF)) else $error("Checker wrong.");
  a_toggle_alt:
    assert property (age_reg != 2'h0 && code_reg == 4'h7 |-> sample_out.a ==
      (age_reg == 2'h1 ? 14'h0000 : ~$past(sample_out.a))) else $error("Toggle wrong.");
  a_ramp_step:
    assert property (age_reg != 2'h0 && code_reg == 4'hF |-> sample_out.a ==
      (age_reg == 2'h1 ? 14'h0000 : $past(sample_out.a) + 14'h0001)) else $error("Ramp wrong.");
endmodule : atpg_gen_chk

bind atpg_gen atpg_gen_chk atpg_gen_chk_inst (.clk_in, .sys_rst_in, .reg_wr_in, .reg_addr_in,
  .reg_wdata_in, .reg_chan_sel_in, .reg_rdata_out, .adc_sample_in, .sample_out,
  .test_active_out, .fmt_bypass_out);

// ===== atpg_fmt_model.sv
// Output formatting stage model fed by the generator.
// Assumes samples arrive registered on clk_in.
`timescale 1ns/1ns
module atpg_fmt_model (
  // Clock and reset.
  input logic clk_in,
  input logic sys_rst_in,
  // Samples from the generator.
  input atpg_pkg::atpg_pair_s sample_in,
  input logic [1:0] bypass_in,
  // Formatted samples toward capture.
  output atpg_pkg::atpg_pair_s fmt_out
);
  import atpg_pkg::*;
  // Offset binary flips the sign bit unless the pattern skips formatting.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      fmt_out <= 28'h0000000;
    else
    begin
      fmt_out.a <= sample_in.a ^ {~bypass_in[0], 13'h0000};
      fmt_out.b <= sample_in.b ^ {~bypass_in[1], 13'h0000};
    end
  end
endmodule : atpg_fmt_model

// ===== atpg_gen_tb.sv
// Self-checking bench for the test-pattern generator.
// Assumes the checker and formatting model are compiled first.
`timescale 1ns/1ns
module atpg_gen_tb;
  import atpg_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [1:0] reg_chan_sel_in = 2'h1;
  logic [7:0] reg_rdata_out;
  atpg_pair_s adc_sample_in = 28'h048CABC;
  logic ddc_mode_in = 1'b0;
  atpg_iq_s [3:0] ddc_in = {4{28'h2AA8555}};
  atpg_pair_s sample_out;
  atpg_pair_s fmt_out;
  logic [1:0] test_active_out;
  logic [1:0] fmt_bypass_out;
  atpg_iq_s [3:0] ddc_out;
  int n_mismatch = 0;
  int num_checks = 0;
  logic hit;
  logic [13:0] user_w [4] = '{14'h0884, 14'h110C, 14'h1995, 14'h221D};
  logic [13:0] pn_w [2][5] = '{'{14'h3FD7, 14'h0002, 14'h26E0, 14'h0A3D, 14'h1CA6},
    '{14'h125B, 14'h3C9A, 14'h2660, 14'h0C65, 14'h0697}};
  logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF, 4'h9};
  logic [11:0] regs [8] = '{ADDR_DDC0_EN, ADDR_DDC1_EN, ADDR_DDC2_EN, ADDR_DDC3_EN,
    ADDR_MODE, ADDR_USER_FIRST, ADDR_USER_LAST, 12'h100};
  atpg_gen atpg_gen_inst (.clk_in, .sys_rst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .reg_chan_sel_in, .reg_rdata_out, .adc_sample_in, .ddc_mode_in, .ddc_in, .sample_out,
    .test_active_out, .fmt_bypass_out, .ddc_out);
  atpg_fmt_model atpg_fmt_model_inst (.clk_in, .sys_rst_in, .sample_in(sample_out),
    .bypass_in(fmt_bypass_out), .fmt_out);
  // Encode clock at 50 MHz.
  always #10 clk_in = ~clk_in;
  // Compares one value and counts it.
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Writes one register, strobe held for one edge.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] s);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_chan_sel_in = s;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  // Presents an address and compares the registered read data.
  task automatic rd(input logic [11:0] a, input logic [1:0] s, input logic [7:0] e);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_chan_sel_in = s;
    @(negedge clk_in);
    chk({6'h00, reg_rdata_out}, {6'h00, e});
  endtask : rd
  // Expected sample k after channel A takes code c.
  function automatic logic [13:0] exp_w(input logic [3:0] c, input int k);
    case (c)
      4'h1: return 14'h0000;
      4'h2: return 14'h1FFF;
      4'h3: return 14'h2000;
      4'h4: return k[0] ? 14'h2AAA : 14'h1555;
      4'h5: return pn_w[0][k];
      4'h6: return pn_w[1][k];
      4'h7: return k[0] ? 14'h3FFF : 14'h0000;
      4'h8: return user_w[k % 4];
      4'hF: return 14'(k);
      default: return adc_sample_in.a;
    endcase
  endfunction : exp_w
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Main sequence of register calls and sample comparisons.
  initial
  begin
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
    wr(12'h100, 8'hFF, 2'h1);
    foreach (regs[i]) rd(regs[i], 2'h1, 8'h00);
    chk(sample_out.a, 14'h0ABC);
    for (int j = 0; j < 8; j++) wr(ADDR_USER_FIRST + 12'(j), 8'(8'h11 * (j + 1)), 2'h1);
    rd(ADDR_USER_LAST, 2'h1, 8'h88);
    foreach (codes[i])
    begin
      wr(ADDR_MODE, {4'h0, codes[i]}, 2'h1);
      for (int k = 0; k < 5; k++)
      begin
        @(negedge clk_in);
        chk(sample_out.a, exp_w(codes[i], k));
      end
      chk(14'(test_active_out[0]), 14'(codes[i] inside {[1:8], 15}));
      chk(14'(fmt_bypass_out[0]), 14'(codes[i] inside {[5:8], 15}));
    end
    wr(ADDR_MODE, 8'h88, 2'h1);
    for (int k = 0; k < 6; k++)
    begin
      @(negedge clk_in);
      chk(sample_out.a, k < 4 ? user_w[k % 4] : 14'h0000);
    end
    ddc_mode_in = 1'b1;
    wr(ADDR_MODE, 8'h02, 2'h3);
    wr(ADDR_MODE, 8'h03, 2'h2);
    wr(ADDR_DDC0_EN, 8'h05, 2'h1);
    wr(ADDR_DDC1_EN, 8'h01, 2'h1);
    rd(ADDR_MODE, 2'h3, 8'h02);
    rd(ADDR_MODE, 2'h2, 8'h03);
    repeat (3) @(negedge clk_in);
    chk(ddc_out[0].i, 14'h1FFF);
    chk(ddc_out[0].q, 14'h2000);
    chk(ddc_out[1].q, 14'h0AAA);
    chk(ddc_out[2].i, 14'h0555);
    chk(fmt_out.a, 14'h3FFF);
    chk(sample_out.b, 14'h2000);
    chk(14'(test_active_out[1]), 14'h0001);
    chk(14'(fmt_bypass_out[1]), 14'h0000);
    chk(fmt_out.b, 14'h0000);
    chk(ddc_out[3].q, 14'h0AAA);
    ddc_mode_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(ddc_out[0].i, 14'h0555);
    for (int r = 0; r < 2; r++)
    begin
      wr(ADDR_MODE, 8'h05 + 8'(r), 2'h1);
      repeat (3) @(negedge clk_in);
      wr(ADDR_MODE, (r == 0 ? 8'h15 : 8'h26), 2'h1);
      wr(ADDR_MODE, 8'h05 + 8'(r), 2'h1);
      hit = 1'b0;
      for (int k = 0; k < 4 && !hit; k++)
      begin
        @(negedge clk_in);
        hit = (sample_out.a === pn_w[r][0]);
      end
      chk(14'(hit), 14'h0001);
      if (!hit) close_out();
      @(negedge clk_in);
      chk(sample_out.a, pn_w[r][1]);
    end
    // A mid-run reset must bring back the converter path and cleared registers.
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    chk(sample_out.a, 14'h0ABC);
    rd(ADDR_USER_FIRST, 2'h1, 8'h00);
    rd(ADDR_MODE, 2'h1, 8'h00);
    close_out();
  end
endmodule : atpg_gen_tb
